// File: include/pcc_defines.vh
// Constants for the counter array edge capture block
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH
`define PCC_NUM_MOD          6
`define PCC_CTRL_OFF         12'h0d8
`define PCC_MODE_BASE        12'h100
`define PCC_CAPL_BASE        12'h140
`define PCC_CAPH_BASE        12'h180
`define PCC_CNTL_OFF         12'h1c0
`define PCC_CNTH_OFF         12'h1c4
`define PCC_IEN_OFF          12'h1c8
`define PCC_CTRL_RESET       8'h00
`define PCC_BIT_OVF          7
`define PCC_BIT_RUN          6
`define PCC_MODE_RISE        0
`define PCC_MODE_FALL        1
`define PCC_IEN_MOD          0
`define PCC_IEN_OVF          1
`define PCC_MIN_WIDTH_CYC    2
`define PCC_CNT_MAX          16'hffff
`endif

// File: rtl/pcc_edge_detect.v
// Capture input synchroniser, width filter and edge detector for one module
`timescale 1ns/1ps
module pcc_edge_detect (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Capture input pin
  input  wire       capture_input_pin,
  // Edge selection
  input  wire       rising_edge_select,
  input  wire       falling_edge_select,
  // Capture request
  output reg        capture_req
);
`include "pcc_defines.vh"

  reg       sync1_q;
  reg       sync2_q;
  reg       stage_q;
  reg [1:0] run_q;
  reg       valid_q;
  reg       accept;

  // Two-flop synchroniser, then level run-length tracking
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q     <= 1'b0;
      sync2_q     <= 1'b0;
      stage_q     <= 1'b0;
      run_q       <= 2'h0;
      valid_q     <= 1'b0;
      capture_req <= 1'b0;
    end else begin
      sync1_q <= capture_input_pin;
      sync2_q <= sync1_q;
      stage_q <= sync2_q;
      if (sync2_q != stage_q)
        run_q <= 2'h1;
      else if (run_q != 2'h3)
        run_q <= run_q + 2'h1;
      // Level accepted only after two held cycles
      if (accept) begin
        valid_q <= stage_q;
      end
      capture_req <= accept && (stage_q != valid_q) &&
                     ((stage_q && rising_edge_select) || (!stage_q && falling_edge_select));
    end
  end

  // Level held long enough to count as valid
  always @* begin
    accept = (sync2_q == stage_q) && (run_q >= (`PCC_MIN_WIDTH_CYC - 1));
  end
endmodule // pcc_edge_detect

// File: rtl/pcc_capture_top.v
// Counter array with six edge capture modules behind an APB slave
// Behaviour
// - A valid edge copies the counter into that module's 16-bit capture register.
// - Rising and falling select bits choose rising, falling or either edge.
// - Each capture sets the module event flag; interrupt raised when enabled.
// - Event flags stay set until software writes them clear.
// - Capture input counts only after holding a level two clock cycles.
// - Counter wrap from ffff to 0000 sets the overflow flag, bit 7.
// - Control bits 5..0 hold module event flags driving the shared interrupt.
`timescale 1ns/1ps
module pcc_capture_top (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Capture input pins
  input  wire [5:0]  capture_input_pin,
  // Interrupt requests
  output reg         module_event_irq,
  output reg         counter_overflow_irq
);
`include "pcc_defines.vh"

  // Register select codes from the address decoder
  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_CTRL = 3'h1;
  localparam [2:0] SEL_CNTL = 3'h2;
  localparam [2:0] SEL_CNTH = 3'h3;
  localparam [2:0] SEL_IEN  = 3'h4;
  localparam [2:0] SEL_MODE = 3'h5;
  localparam [2:0] SEL_CAPL = 3'h6;
  localparam [2:0] SEL_CAPH = 3'h7;

  // Architectural state
  reg  [7:0]  ctrl_q;
  reg  [15:0] count_q;
  reg  [1:0]  mode_q [0:5];
  reg  [15:0] cap_q  [0:5];
  reg  [1:0]  ien_q;

  // Decode results and next values
  wire [5:0]  cap_req;
  reg  [5:0]  flag_set;
  reg         ovf_set;
  reg  [2:0]  reg_sel;
  reg  [2:0]  mod_idx;
  reg         wr_en;
  reg         wr_ctrl;
  reg         wr_cnt_lo;
  reg         wr_cnt_hi;
  reg         wr_ien;
  reg  [5:0]  wr_mode;
  reg  [7:0]  ctrl_d;
  reg  [15:0] count_d;
  reg  [1:0]  ien_d;
  reg  [31:0] rdata_d;
  reg         hit_d;
  reg         pready_d;
  reg         pslverr_d;
  reg  [31:0] prdata_d;
  reg         evt_irq_d;
  reg         ovf_irq_d;
  integer     i;
  integer     j;

  // Module index from an address within a bank, or 7 on miss
  function [2:0] mod_index;
    input [11:0] addr;
    input [11:0] base;
    reg   [11:0] off;
    begin
      off = addr - base;
      if (addr >= base && off < 12'h018 && off[1:0] == 2'h0)
        mod_index = off[4:2];
      else
        mod_index = 3'h7;
    end
  endfunction

  // One-hot strobe for the addressed module
  function [5:0] mod_onehot;
    input       en;
    input [2:0] idx;
    begin
      mod_onehot = 6'h00;
      if (en && idx < 3'h6)
        mod_onehot[idx] = 1'b1;
    end
  endfunction

  // Zero-extended low or high byte of a 16-bit value
  function [31:0] byte_of;
    input [15:0] val;
    input        hi;
    begin
      if (hi)
        byte_of = {24'h000000, val[15:8]};
      else
        byte_of = {24'h000000, val[7:0]};
    end
  endfunction

  // Replace the low or high byte of a 16-bit value
  function [15:0] load_byte;
    input [15:0] val;
    input        hi;
    input [7:0]  b;
    begin
      if (hi)
        load_byte = {b, val[7:0]};
      else
        load_byte = {val[15:8], b};
    end
  endfunction

  // One filter and edge detector per module
  genvar g;
  generate
    for (g = 0; g < `PCC_NUM_MOD; g = g + 1) begin : g_mod
      pcc_edge_detect u_det (
        .pclk                (pclk),
        .presetn             (presetn),
        .capture_input_pin   (capture_input_pin[g]),
        .rising_edge_select  (mode_q[g][`PCC_MODE_RISE]),
        .falling_edge_select (mode_q[g][`PCC_MODE_FALL]),
        .capture_req         (cap_req[g])
      );
    end
  endgenerate

  // Address decoder: register select and module index
  always @* begin
    reg_sel = SEL_NONE;
    mod_idx = 3'h0;
    if (paddr == `PCC_CTRL_OFF) begin
      reg_sel = SEL_CTRL;
    end else if (paddr == `PCC_CNTL_OFF) begin
      reg_sel = SEL_CNTL;
    end else if (paddr == `PCC_CNTH_OFF) begin
      reg_sel = SEL_CNTH;
    end else if (paddr == `PCC_IEN_OFF) begin
      reg_sel = SEL_IEN;
    end else if (mod_index(paddr, `PCC_MODE_BASE) != 3'h7) begin
      reg_sel = SEL_MODE;
      mod_idx = mod_index(paddr, `PCC_MODE_BASE);
    end else if (mod_index(paddr, `PCC_CAPL_BASE) != 3'h7) begin
      reg_sel = SEL_CAPL;
      mod_idx = mod_index(paddr, `PCC_CAPL_BASE);
    end else if (mod_index(paddr, `PCC_CAPH_BASE) != 3'h7) begin
      reg_sel = SEL_CAPH;
      mod_idx = mod_index(paddr, `PCC_CAPH_BASE);
    end
  end

  // Write strobes, taken at the edge that samples pready high
  always @* begin
    wr_en     = psel && penable && pwrite && pready;
    wr_ctrl   = wr_en && (reg_sel == SEL_CTRL);
    wr_cnt_lo = wr_en && (reg_sel == SEL_CNTL);
    wr_cnt_hi = wr_en && (reg_sel == SEL_CNTH);
    wr_ien    = wr_en && (reg_sel == SEL_IEN);
    wr_mode   = mod_onehot(wr_en && (reg_sel == SEL_MODE), mod_idx);
  end

  // Hardware set terms for the control register
  always @* begin
    flag_set = cap_req;
    ovf_set  = ctrl_q[`PCC_BIT_RUN] && (count_q == `PCC_CNT_MAX);
  end

  // Counter next value: count while running, load bytes only while stopped
  always @* begin
    count_d = count_q;
    if (ctrl_q[`PCC_BIT_RUN]) begin
      count_d = count_q + 16'h0001;
    end else if (wr_cnt_lo) begin
      count_d = load_byte(count_q, 1'b0, pwdata[7:0]);
    end else if (wr_cnt_hi) begin
      count_d = load_byte(count_q, 1'b1, pwdata[7:0]);
    end
  end

  // Counter register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 16'h0000;
    end else begin
      count_q <= count_d;
    end
  end

  // Control next value: software write, hardware set wins
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
      ctrl_d = pwdata[7:0];
    ctrl_d[`PCC_BIT_OVF] = ctrl_d[`PCC_BIT_OVF] | ovf_set;
    ctrl_d[5:0]          = ctrl_d[5:0] | flag_set;
  end

  // Control register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `PCC_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Interrupt enable next value
  always @* begin
    ien_d = ien_q;
    if (wr_ien)
      ien_d = pwdata[1:0];
  end

  // Interrupt enable register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_q <= 2'h0;
    end else begin
      ien_q <= ien_d;
    end
  end

  // Edge select bits per module
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < `PCC_NUM_MOD; i = i + 1) begin
        mode_q[i] <= 2'h0;
      end
    end else begin
      for (i = 0; i < `PCC_NUM_MOD; i = i + 1) begin
        if (wr_mode[i])
          mode_q[i] <= pwdata[1:0];
      end
    end
  end

  // Capture registers load the counter on a qualified edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (j = 0; j < `PCC_NUM_MOD; j = j + 1) begin
        cap_q[j] <= 16'h0000;
      end
    end else begin
      for (j = 0; j < `PCC_NUM_MOD; j = j + 1) begin
        if (cap_req[j])
          cap_q[j] <= count_q;
      end
    end
  end

  // Read data select; unmapped addresses flag an error
  always @* begin
    rdata_d = 32'h0000_0000;
    hit_d   = 1'b1;
    case (reg_sel)
      SEL_CTRL: rdata_d = {24'h000000, ctrl_q};
      SEL_CNTL: rdata_d = byte_of(count_q, 1'b0);
      SEL_CNTH: rdata_d = byte_of(count_q, 1'b1);
      SEL_IEN:  rdata_d = {30'h0, ien_q};
      SEL_MODE: rdata_d = {30'h0, mode_q[mod_idx]};
      SEL_CAPL: rdata_d = byte_of(cap_q[mod_idx], 1'b0);
      SEL_CAPH: rdata_d = byte_of(cap_q[mod_idx], 1'b1);
      default:  hit_d   = 1'b0;
    endcase
  end

  // APB response next values: one wait state, pready in the access phase
  always @* begin
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = prdata;
    if (psel && penable && !pready) begin
      pready_d  = 1'b1;
      pslverr_d = !hit_d;
      prdata_d  = pwrite ? 32'h0000_0000 : rdata_d;
    end
  end

  // APB response registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= pready_d;
      prdata  <= prdata_d;
      pslverr <= pslverr_d;
    end
  end

  // Interrupt requests follow flags and enables
  always @* begin
    evt_irq_d = ien_q[`PCC_IEN_MOD] && (|ctrl_q[5:0]);
    ovf_irq_d = ien_q[`PCC_IEN_OVF] && ctrl_q[`PCC_BIT_OVF];
  end

  // Interrupt request registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_event_irq     <= 1'b0;
      counter_overflow_irq <= 1'b0;
    end else begin
      module_event_irq     <= evt_irq_d;
      counter_overflow_irq <= ovf_irq_d;
    end
  end
endmodule // pcc_capture_top

// File: verification/pcc_capture_checker.sv
// Bus timing and flag holding checker for the capture block
`timescale 1ns/1ps
module pcc_capture_checker (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // Bus and interrupt lines
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        module_event_irq,
  input wire        counter_overflow_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus handshake
  property p_wait; psel && penable && !pready |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_sel; pready |-> psel && penable; endproperty
  property p_idle; !psel |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_rdz; pslverr && !pwrite |-> prdata == 32'h0; endproperty
  // Flags only drop after a write
  property p_evt; module_event_irq && !psel && !$past(psel) |=> module_event_irq; endproperty
  property p_ovf; counter_overflow_irq && !psel && !$past(psel) |=> counter_overflow_irq; endproperty
  a_wait: assert property (p_wait) else $error("late ready");
  a_pulse: assert property (p_pulse) else $error("long ready");
  a_sel: assert property (p_sel) else $error("stray ready");
  a_idle: assert property (p_idle) else $error("idle ready");
  a_err: assert property (p_err) else $error("stray error");
  a_rdz: assert property (p_rdz) else $error("refused read not zero");
  a_evt: assert property (p_evt) else $error("event flag dropped");
  a_ovf: assert property (p_ovf) else $error("overflow flag dropped");
  c_evt: cover property ($rose(module_event_irq));
  c_ovf: cover property ($rose(counter_overflow_irq));
  c_err: cover property (pslverr);
endmodule // pcc_capture_checker

bind pcc_capture_top pcc_capture_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .module_event_irq(module_event_irq),
  .counter_overflow_irq(counter_overflow_irq));

// File: verification/pcc_pin_driver.sv
// External signal model for the six capture inputs
`timescale 1ns/1ps
module pcc_pin_driver (
  // Clock
  input wire       pclk,
  // Requested level and one-cycle upset
  input wire [5:0] want,
  input wire [5:0] glitch,
  // Capture input pins
  output reg [5:0] pin
);
  // Level follows the request; a glitch breaks the width on purpose
  initial pin = 6'h00;
  always @(posedge pclk) pin <= want ^ glitch;
endmodule // pcc_pin_driver

// File: verification/tb_top.sv
// Self-checking bench for the edge capture block
`timescale 1ns/1ps
`include "pcc_defines.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; $display("mismatch %0t %h %h", $time, a, e); end end
module tb_top;
  reg         pclk, presetn, psel, penable, pwrite, err;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [5:0]  want, glitch;
  wire [31:0] prdata;
  wire [5:0]  pin;
  wire        pready, pslverr, mirq, oirq;
  int         fails, n_checks, flags, v, n, e;
  int         exp_q[$];
  pcc_capture_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_pin(pin), .module_event_irq(mirq), .counter_overflow_irq(oirq));
  pcc_pin_driver PIN (.pclk(pclk), .want(want), .glitch(glitch), .pin(pin));
  // Clock
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  // Verdict
  task wrap_up;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One bus transfer, held until ready
  task apb(input [11:0] a, input w, input [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Drive all pins, then compare flags and captures with the model
  task edge_run(input [5:0] lv, input int sel);
    flags = 0;
    want <= lv;
    repeat (12) @(posedge pclk);
    for (n = 0; n < 6; n++) if ((n % 3 + 1) & sel) begin
      flags |= 1 << n;
      exp_q.push_back(v[15:0]);
    end
    apb(`PCC_CTRL_OFF, 0, 0); `CHK(rd, flags)
    `CHK(mirq, flags != 0)
    for (n = 0; n < 6; n++) if (flags[n]) begin
      e = exp_q.pop_front();
      apb(12'(`PCC_CAPL_BASE + 4 * n), 0, 0); `CHK(rd, e[7:0])
      apb(12'(`PCC_CAPH_BASE + 4 * n), 0, 0); `CHK(rd, e[15:8])
    end
    apb(`PCC_CTRL_OFF, 1, 0);
  endtask
  // Watchdog
  initial begin
    #20000;
    fails++;
    wrap_up;
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, want, glitch} = 0;
    presetn = 0;
    void'($urandom(41231));
    v = $urandom;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(`PCC_CTRL_OFF, 0, 0); `CHK(rd, `PCC_CTRL_RESET)
    for (n = 0; n < 6; n++) apb(12'(`PCC_MODE_BASE + 4 * n), 1, n % 3 + 1);
    apb(`PCC_CNTL_OFF, 1, v[7:0]);
    apb(`PCC_CNTH_OFF, 1, v[15:8]);
    apb(`PCC_IEN_OFF, 1, 3);
    apb(`PCC_CNTL_OFF, 0, 0); `CHK(rd, v[7:0])
    edge_run(6'h3f, 1);
    edge_run(6'h00, 2);
    glitch <= 6'h3f;
    @(posedge pclk) glitch <= 0;
    repeat (12) @(posedge pclk);
    apb(`PCC_CTRL_OFF, 0, 0); `CHK(rd, 0)
    glitch <= 6'h3f;
    repeat (2) @(posedge pclk);
    glitch <= 0;
    edge_run(6'h00, 3);
    apb(`PCC_CNTL_OFF, 1, 32'hf0);
    apb(`PCC_CNTH_OFF, 1, 32'hff);
    apb(`PCC_CTRL_OFF, 1, 32'h40);
    repeat (30) @(posedge pclk);
    apb(`PCC_CTRL_OFF, 0, 0); `CHK(rd, 32'hc0)
    `CHK(oirq, 1'b1)
    apb(12'h004, 0, 0); `CHK({err, rd}, 33'h100000000)
    wrap_up;
  end
endmodule // tb_top
